/* File: taa_alarm.sv */
// Temperature alarm flags, alert output, alert response and critical alarm
//
// Summary of operation
// - Compare each finished reading against its limits
// - Over high/crit or under low sets flag
// - Unmasked set flags except busy/open pull alert
// - Alert asserts only while mask bit is zero
// - Comparator mode releases alert when condition ends
// - Interrupt mode status read with flags sets mask
// - Non-critical flags clear on status read, reset next conversion
// - Mask set keeps alert released until cleared
// - Answer alert response read by sending address
// - Full address sent: release alert, set mask
// - Address bit seen wrong: alert and mask unchanged
// - Alert response address is 000 1100
// - Answer alert response only in interrupt mode
// - Mask and alert-configure reset to zero
// - Critical alarm asserts when reading exceeds critical
// - Alternate conversions update alarm and flags each time
// - Critical alarm releases below critical minus hysteresis
// - Critical flag clears after read and reading below
// - One hysteresis value serves both channels
// - Busy bit high only during conversion
`timescale 1ns/1ps
module taa_alarm
   import taa_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire taa_conv_t conv,
   input wire logic open_fault,
   input wire logic [7:0] local_high_limit,
   input wire logic [7:0] local_low_limit,
   input wire logic [7:0] local_crit_limit,
   input wire logic [7:0] remote_high_limit,
   input wire logic [7:0] remote_low_limit,
   input wire logic [7:0] remote_crit_limit,
   input wire logic [7:0] crit_hysteresis,
   input wire taa_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic smb_clk_i,
   input wire logic smb_data_i,
   output logic smb_data_o,
   output logic smb_data_oe,
   output logic alert_n_o,
   output logic alert_n_oe,
   output logic crit_alarm_n_o,
   output logic crit_alarm_n_oe
);
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] cfg;
      logic [7:0] alcfg;
      logic [7:0] cond;
      logic [1:0] crit_on;
      logic [7:0] rdata;
      logic busy;
      logic alert_oe;
      logic crit_oe;
      logic sda_oe;
      logic drive_lvl;
      taa_ara_t ara;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic scl_d;
      logic sda_d;
   } taa_alarm_st_t;

   taa_alarm_st_t q;
   taa_alarm_st_t d;
   logic [1:0] pins;
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   taa_limits_t lim_sel;
   taa_cmp_t cmp;
   logic [7:0] chan;
   logic [7:0] newf;
   logic st_rd;
   logic start;
   logic stop;
   logic rise;
   logic fall;

   assign pins = {smb_clk_i, smb_data_i};

   // Bus clock and data are foreign to mclk
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_sync
         taa_sync u_sync (
            .mclk(mclk),
            .srst(srst),
            .pin(pins[gi]),
            .pin_s(pins_s[gi])
         );
      end
   endgenerate
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   // One comparator serves both channels; conversions never overlap
   always_comb
   begin
      if (conv.remote)
         lim_sel = '{high: remote_high_limit, low: remote_low_limit, crit: remote_crit_limit};
      else
         lim_sel = '{high: local_high_limit, low: local_low_limit, crit: local_crit_limit};
   end
   taa_limit_cmp u_cmp (
      .reading(conv.value),
      .lim(lim_sel),
      .hyst(crit_hysteresis),
      .crit_on_q(q.crit_on[conv.remote]),
      .res(cmp)
   );
   always_comb
   begin
      d = q;
      d.drive_lvl = 1'b0;
      d.scl_d = scl_s;
      d.sda_d = sda_s;
      start = scl_s && q.scl_d && q.sda_d && !sda_s;
      stop = scl_s && q.scl_d && !q.sda_d && sda_s;
      rise = scl_s && !q.scl_d;
      fall = !scl_s && q.scl_d;
      chan = taa_chan_bits(conv.remote, 1'b1, 1'b1, 1'b1);
      newf = taa_chan_bits(conv.remote, cmp.over_high, cmp.under_low, cmp.over_crit);
      st_rd = reg_req.rd && (reg_req.addr == TAA_OFS_STATUS);
      // Software writes first, so hardware mask sets below win over a clear
      if (reg_req.wr && reg_req.addr == TAA_OFS_CONFIG)
         d.cfg = reg_req.wdata;
      if (reg_req.wr && reg_req.addr == TAA_OFS_ALCFG)
         d.alcfg = reg_req.wdata;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            TAA_OFS_STATUS: d.rdata = {q.busy, q.status[6:0]};
            TAA_OFS_CONFIG: d.rdata = q.cfg;
            TAA_OFS_ALCFG: d.rdata = q.alcfg;
            default: d.rdata = 8'h00;
         endcase
      end
      if (st_rd)
      begin
         // Critical flags survive while their channel still reads above
         d.status = q.status & q.cond & TAA_CRIT_BITS;
         if (!q.alcfg[TAA_ALCFG_CMP] && |(q.status & TAA_ALERT_BITS))
            d.cfg[TAA_CFG_MASK] = 1'b1;
      end
      // A conversion ending in the read cycle still sets its flags
      if (conv.done)
      begin
         d.cond = (q.cond & ~chan) | newf;
         d.status = d.status | newf;
         if (conv.remote && open_fault)
            d.status = d.status | TAA_OPEN_BIT;
         d.crit_on[conv.remote] = cmp.crit_on;
      end
      d.busy = conv.busy;
      unique case (q.ara)
         TAA_ARA_IDLE:
         begin
         end
         TAA_ARA_RXADDR:
         begin
            if (rise)
            begin
               d.shift = {q.shift[6:0], sda_s};
               d.bitcnt = q.bitcnt + 4'h1;
               if (q.bitcnt == TAA_LAST_BIT)
                  d.ara = TAA_ARA_ACKW;
            end
         end
         TAA_ARA_ACKW:
         begin
            if (fall)
            begin
               if (q.shift == {TAA_ARA_ADDR, 1'b1} && q.alert_oe &&
                   !q.alcfg[TAA_ALCFG_CMP])
               begin
                  d.sda_oe = 1'b1;
                  d.ara = TAA_ARA_ACK;
               end
               else
                  d.ara = TAA_ARA_IDLE;
            end
         end
         TAA_ARA_ACK:
         begin
            if (fall)
            begin
               d.shift = {TAA_OWN_ADDR, 1'b0};
               d.bitcnt = 4'h0;
               d.sda_oe = ~TAA_OWN_ADDR[6];
               d.ara = TAA_ARA_SEND;
            end
         end
         TAA_ARA_SEND:
         begin
            if (rise)
            begin
               if (sda_s != q.shift[7])
               begin
                  // Lost to another alerting device; try again on a later read
                  d.sda_oe = 1'b0;
                  d.ara = TAA_ARA_IDLE;
               end
               else
               begin
                  d.shift = {q.shift[6:0], 1'b0};
                  d.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == TAA_LAST_BIT)
                  begin
                     d.cfg[TAA_CFG_MASK] = 1'b1;
                     d.ara = TAA_ARA_DONE;
                  end
               end
            end
            else if (fall)
               d.sda_oe = ~q.shift[7];
         end
         TAA_ARA_DONE:
         begin
            if (fall)
            begin
               d.sda_oe = 1'b0;
               d.ara = TAA_ARA_IDLE;
            end
         end
         default:
         begin
            d.sda_oe = 1'b0;
            d.ara = TAA_ARA_IDLE;
         end
      endcase
      // A start resynchronises the responder at any point
      if (start)
      begin
         d.ara = TAA_ARA_RXADDR;
         d.bitcnt = 4'h0;
         d.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         d.ara = TAA_ARA_IDLE;
         d.sda_oe = 1'b0;
      end
      if (d.alcfg[TAA_ALCFG_CMP])
         d.alert_oe = !d.cfg[TAA_CFG_MASK] && |(d.cond & TAA_ALERT_BITS);
      else
         d.alert_oe = !d.cfg[TAA_CFG_MASK] && |(d.status & TAA_ALERT_BITS);
      d.crit_oe = |d.crit_on;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         q <= '0;
         q.status <= TAA_STATUS_RST;
         q.cfg <= TAA_CONFIG_RST;
         q.alcfg <= TAA_ALCFG_RST;
         {q.scl_d, q.sda_d} <= 2'b11;
      end
      else
         q <= d;
   end

   assign reg_rdata = q.rdata;
   assign smb_data_o = q.drive_lvl;
   assign smb_data_oe = q.sda_oe;
   assign alert_n_o = q.drive_lvl;
   assign alert_n_oe = q.alert_oe;
   assign crit_alarm_n_o = q.drive_lvl;
   assign crit_alarm_n_oe = q.crit_oe;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   property p_mask_blocks;
      q.cfg[TAA_CFG_MASK] |-> !alert_n_oe;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("alert while masked");
   property p_int_read_masks;
      st_rd && !q.alcfg[TAA_ALCFG_CMP] && |(q.status & TAA_ALERT_BITS)
         |=> q.cfg[TAA_CFG_MASK] && !alert_n_oe;
   endproperty
   a_int_read_masks: assert property (p_int_read_masks) else $error("read did not mask");
   property p_cmp_read_nomask;
      st_rd && q.alcfg[TAA_ALCFG_CMP] && !q.cfg[TAA_CFG_MASK] && !reg_req.wr
         |=> !q.cfg[TAA_CFG_MASK];
   endproperty
   a_cmp_read_nomask: assert property (p_cmp_read_nomask) else $error("cmp read masked");
   property p_cmp_follows;
      q.alcfg[TAA_ALCFG_CMP] |-> alert_n_oe ==
         (!q.cfg[TAA_CFG_MASK] && |(q.cond & TAA_ALERT_BITS));
   endproperty
   a_cmp_follows: assert property (p_cmp_follows) else $error("cmp alert wrong");
   property p_read_clears;
      st_rd && !conv.done |=> (q.status & ~TAA_CRIT_BITS) == 8'h00;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flags not cleared");
   property p_high_flag;
      conv.done && !conv.remote && $signed(conv.value) > $signed(local_high_limit)
         |=> q.status[TAA_ST_LHIGH] ##1 q.status[TAA_ST_LHIGH] || $past(st_rd);
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("high flag missing");
   property p_crit_on;
      conv.done && conv.remote && $signed(conv.value) > $signed(remote_crit_limit)
         |=> ##1 crit_alarm_n_oe;
   endproperty
   a_crit_on: assert property (p_crit_on) else $error("crit alarm missing");
   // The alarm may only move in the cycle after a finished conversion
   property p_crit_hold;
      !conv.done |=> $stable(crit_alarm_n_oe);
   endproperty
   a_crit_hold: assert property (p_crit_hold) else $error("crit changed idle");
   // Busy read back is the converter's level one cycle before the read
   property p_busy;
      st_rd |=> reg_rdata[TAA_ST_BUSY] == $past(conv.busy, 2);
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_lost_bit;
      q.ara == TAA_ARA_SEND && rise && !start && sda_s != q.shift[7]
         |=> !smb_data_oe && $stable(q.cfg[TAA_CFG_MASK]) || $past(reg_req.wr);
   endproperty
   a_lost_bit: assert property (p_lost_bit) else $error("lost bit not released");
   property p_no_ack_cmp;
      q.alcfg[TAA_ALCFG_CMP] && q.ara == TAA_ARA_ACKW |=> q.ara != TAA_ARA_ACK;
   endproperty
   a_no_ack_cmp: assert property (p_no_ack_cmp) else $error("acked in cmp mode");
   c_alert: cover property (!alert_n_oe ##1 alert_n_oe);
   c_ara_done: cover property (q.ara == TAA_ARA_DONE);
   c_crit: cover property (crit_alarm_n_oe ##1 !crit_alarm_n_oe);
endmodule

/* File: taa_pkg.sv */
// Shared constants and types for the temperature alarm and alert logic
package taa_pkg;
   // Register offsets
   localparam logic [7:0] TAA_OFS_STATUS = 8'h02;
   localparam logic [7:0] TAA_OFS_CONFIG = 8'h09;
   localparam logic [7:0] TAA_OFS_ALCFG = 8'hbf;
   // Reset values
   localparam logic [7:0] TAA_STATUS_RST = 8'h00;
   localparam logic [7:0] TAA_CONFIG_RST = 8'h00;
   localparam logic [7:0] TAA_ALCFG_RST = 8'h00;
   // Status bit positions
   localparam int TAA_ST_BUSY = 7;
   localparam int TAA_ST_LHIGH = 6;
   localparam int TAA_ST_LLOW = 5;
   localparam int TAA_ST_RHIGH = 4;
   localparam int TAA_ST_RLOW = 3;
   localparam int TAA_ST_OPEN = 2;
   localparam int TAA_ST_RCRIT = 1;
   localparam int TAA_ST_LCRIT = 0;
   // Status bits that may pull the alert line, and the critical bits
   localparam logic [7:0] TAA_ALERT_BITS = 8'h7b;
   localparam logic [7:0] TAA_CRIT_BITS = 8'h03;
   localparam logic [7:0] TAA_OPEN_BIT = 8'h04;
   // Configuration and alert-configure bit positions
   localparam int TAA_CFG_MASK = 7;
   localparam int TAA_ALCFG_CMP = 0;
   // Alert response address and own slave address (own value is arbitrary)
   localparam logic [6:0] TAA_ARA_ADDR = 7'h0c;
   localparam logic [6:0] TAA_OWN_ADDR = 7'h2a;
   localparam logic [3:0] TAA_LAST_BIT = 4'h7;

   typedef enum logic [2:0] {
      TAA_ARA_IDLE,
      TAA_ARA_RXADDR,
      TAA_ARA_ACKW,
      TAA_ARA_ACK,
      TAA_ARA_SEND,
      TAA_ARA_DONE
   } taa_ara_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic remote;
      logic [7:0] value;
   } taa_conv_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } taa_reg_req_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic [7:0] crit;
   } taa_limits_t;

   typedef struct packed {
      logic over_high;
      logic under_low;
      logic over_crit;
      logic crit_on;
   } taa_cmp_t;

   // Places one channel's limit results at that channel's status positions
   function automatic logic [7:0] taa_chan_bits(input logic remote, input logic hi,
                                                input logic lo, input logic cr);
      logic [7:0] f;
      f = 8'h00;
      if (remote)
      begin
         f[TAA_ST_RHIGH] = hi;
         f[TAA_ST_RLOW] = lo;
         f[TAA_ST_RCRIT] = cr;
      end
      else
      begin
         f[TAA_ST_LHIGH] = hi;
         f[TAA_ST_LLOW] = lo;
         f[TAA_ST_LCRIT] = cr;
      end
      return f;
   endfunction
endpackage

/* File: taa_sync.sv */
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
module taa_sync
   import taa_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic pin,
   output logic pin_s
);
   typedef struct packed {
      logic s1;
      logic s2;
   } taa_sync_st_t;

   taa_sync_st_t q;
   taa_sync_st_t d;

   always_comb
   begin
      d.s1 = pin;
      d.s2 = q.s1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         q <= '1;
      else
         q <= d;
   end

   assign pin_s = q.s2;
endmodule

/* File: taa_limit_cmp.sv */
// Limit comparison of one reading, with critical hysteresis
`timescale 1ns/1ps
module taa_limit_cmp
   import taa_pkg::*;
(
   input wire logic [7:0] reading,
   input wire taa_limits_t lim,
   input wire logic [7:0] hyst,
   input wire logic crit_on_q,
   output taa_cmp_t res
);
   logic signed [9:0] rd_w;
   logic signed [9:0] thr_w;

   always_comb
   begin
      rd_w = {{2{reading[7]}}, reading};
      // Wide enough that crit minus a large hysteresis cannot wrap
      thr_w = $signed({{2{lim.crit[7]}}, lim.crit}) - $signed({2'b00, hyst});
      res.over_high = $signed(reading) > $signed(lim.high);
      res.under_low = $signed(reading) < $signed(lim.low);
      res.over_crit = $signed(reading) > $signed(lim.crit);
      if (res.over_crit)
         res.crit_on = 1'b1;
      else if (rd_w < thr_w)
         res.crit_on = 1'b0;
      else
         res.crit_on = crit_on_q;
   end
endmodule

/* File: taa_host_model.sv */
// Behavioural SMBus host that services the shared alert line by alert response reads
`timescale 1ns/1ps
module taa_host_model
(
   output logic scl,
   output logic sda_oe,
   input wire logic sda,
   input wire logic alert_n
);
   // Clock stands high between frames; 400 ns bit period
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic put_bit(input logic b);
      scl = 1'b0;
      #100 sda_oe = ~b;
      #100 scl = 1'b1;
      #200;
   endtask

   // With clash set a rival with a lower address holds data low, so arbitration is lost
   task automatic get_bit(input logic clash, output logic b);
      scl = 1'b0;
      #100 sda_oe = clash;
      #100 scl = 1'b1;
      #150 b = sda;
      #50;
   endtask

   task automatic ara(input logic clash, output logic ack, output logic [7:0] got);
      logic b;
      logic [7:0] a;
      a = 8'h19;
      ack = 1'b1;
      got = 8'hff;
      if (alert_n === 1'b0)
      begin
         sda_oe = 1'b1;
         #200;
         for (int i = 7; i >= 0; i--)
            put_bit(a[i]);
         get_bit(1'b0, ack);
         for (int i = 7; i >= 0; i--)
         begin
            get_bit(clash, b);
            got[i] = b;
         end
         put_bit(1'b1);
         scl = 1'b0;
         #100 sda_oe = 1'b1;
         #100 scl = 1'b1;
         #100 sda_oe = 1'b0;
         #200;
      end
   endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the alarm flags, alert output and critical alarm
`timescale 1ns/1ps
module tb
   import taa_pkg::*;
;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   taa_conv_t conv_s = '0;
   logic open_fault = 1'b0;
   logic [7:0] lim_h [2] = '{8'h50, 8'h40};
   logic [7:0] lim_l [2] = '{8'hf0, 8'h00};
   logic [7:0] lim_c [2] = '{8'h60, 8'h55};
   logic [7:0] hyst = 8'h05;
   logic [7:0] corner [6] = '{8'h61, 8'h56, 8'h5c, 8'h51, 8'h5a, 8'h4f};
   taa_reg_req_t req = '0;
   logic [7:0] rdata, st, got, v;
   logic scl, host_oe, sda_oe, sda_o, al_oe, al_o, cr_oe, cr_o, ack, ch, of;
   logic mask = 1'b0;
   logic cmp = 1'b0;
   logic on [2] = '{1'b0, 1'b0};
   logic above [2] = '{1'b0, 1'b0};
   wire sda = ~((sda_oe & ~sda_o) | host_oe);
   wire alert_n = ~(al_oe & ~al_o);
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   integer seed = 32'h62afcbfc;

   always #25 mclk = ~mclk;

   taa_alarm i_dut (
      .mclk(mclk), .srst(srst), .conv(conv_s), .open_fault(open_fault),
      .local_high_limit(lim_h[0]), .local_low_limit(lim_l[0]), .local_crit_limit(lim_c[0]),
      .remote_high_limit(lim_h[1]), .remote_low_limit(lim_l[1]),
      .remote_crit_limit(lim_c[1]), .crit_hysteresis(hyst), .reg_req(req), .reg_rdata(rdata),
      .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(sda_o), .smb_data_oe(sda_oe),
      .alert_n_o(al_o), .alert_n_oe(al_oe), .crit_alarm_n_o(cr_o), .crit_alarm_n_oe(cr_oe)
   );

   taa_host_model i_host (.scl(scl), .sda_oe(host_oe), .sda(sda), .alert_n(alert_n));

   task automatic report_and_stop();
      $display("tb: %0d comparisons, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         report_and_stop();
      end
   end

   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 chk8(rdata, e, "read data");
   endtask

   // Expected flags of one finished reading, signed compares
   function automatic logic [7:0] flags(input logic c, input logic [7:0] r, input logic f);
      logic hi;
      logic lo;
      logic cr;
      hi = $signed(r) > $signed(lim_h[c]);
      lo = $signed(r) < $signed(lim_l[c]);
      cr = $signed(r) > $signed(lim_c[c]);
      return c ? {3'b000, hi, lo, f, cr, 1'b0} : {1'b0, hi, lo, 4'b0000, cr};
   endfunction

   task automatic step(input logic c, input logic [7:0] r, input logic f);
      int vi;
      int ci;
      @(posedge mclk);
      conv_s <= '{busy: 1'b0, done: 1'b1, remote: c, value: r};
      open_fault <= f;
      @(posedge mclk);
      conv_s.done <= 1'b0;
      tick(1);
      vi = $signed(r);
      ci = $signed(lim_c[c]);
      above[c] = vi > ci;
      if (vi > ci)
         on[c] = 1'b1;
      else if (vi < ci - int'(hyst))
         on[c] = 1'b0;
      st = st | flags(c, r, f);
      chk1(cr_oe, on[0] | on[1], "critical alarm");
      chk1(cr_o, 1'b0, "critical alarm level");
      if (!cmp)
         chk1(al_oe, |(st & 8'h7b) & ~mask, "alert");
   endtask

   // Critical flags survive a read while their channel is still above the limit
   task automatic rdst(input logic b);
      @(posedge mclk);
      conv_s.busy <= b;
      rdchk(TAA_OFS_STATUS, {b, st[6:0]});
      if (!cmp && |(st & 8'h7b))
         mask = 1'b1;
      st = {6'h00, above[1], above[0]};
      if (!cmp)
         chk1(al_oe, 1'b0, "alert after read");
   endtask

   task automatic setmask(input logic m);
      wr(TAA_OFS_CONFIG, {m, 7'h00});
      mask = m;
      tick(2);
   endtask

   initial
   begin
      st = 8'h00;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      rdst(1'b0);
      rdchk(TAA_OFS_CONFIG, 8'h00);
      rdchk(TAA_OFS_ALCFG, 8'h00);
      rdchk(8'h55, 8'h00);
      wr(TAA_OFS_STATUS, 8'hff);
      rdst(1'b0);
      wr(TAA_OFS_CONFIG, 8'h3c);
      rdchk(TAA_OFS_CONFIG, 8'h3c);
      setmask(1'b1);
      step(1'b0, 8'h55, 1'b0);
      setmask(1'b0);
      chk1(al_oe, 1'b1, "alert unmasked");
      rdst(1'b0);
      rdchk(TAA_OFS_CONFIG, 8'h80);
      step(1'b0, 8'h55, 1'b0);
      rdst(1'b1);
      setmask(1'b0);
      // Alert response: first lost to a rival, then won
      step(1'b0, 8'h55, 1'b0);
      i_host.ara(1'b1, ack, got);
      chk1(ack, 1'b0, "ara ack");
      tick(4);
      chk1(al_oe, 1'b1, "alert kept");
      rdchk(TAA_OFS_CONFIG, 8'h00);
      i_host.ara(1'b0, ack, got);
      chk1(ack, 1'b0, "ara ack");
      chk8(got, {TAA_OWN_ADDR, 1'b0}, "ara address");
      tick(4);
      chk1(al_oe, 1'b0, "alert released");
      rdchk(TAA_OFS_CONFIG, 8'h80);
      mask = 1'b1;
      rdst(1'b0);
      setmask(1'b0);
      // Comparator mode
      wr(TAA_OFS_ALCFG, 8'h01);
      cmp = 1'b1;
      step(1'b0, 8'h55, 1'b0);
      chk1(al_oe, 1'b1, "comparator alert");
      rdst(1'b0);
      rdchk(TAA_OFS_CONFIG, 8'h00);
      chk1(al_oe, 1'b1, "comparator alert");
      step(1'b0, 8'h10, 1'b0);
      chk1(al_oe, 1'b0, "comparator release");
      step(1'b0, 8'h55, 1'b0);
      i_host.ara(1'b0, ack, got);
      chk1(ack, 1'b1, "ara ignored");
      wr(TAA_OFS_ALCFG, 8'h00);
      cmp = 1'b0;
      rdst(1'b0);
      setmask(1'b0);
      // Alternate channels: hysteresis corners first, then random limits and readings
      for (int i = 0; i < 46; i++)
      begin
         ch = i[0];
         if (i < 6)
            v = corner[i];
         else
         begin
            @(posedge mclk);
            lim_h[ch] <= 8'($random(seed));
            lim_l[ch] <= 8'($random(seed));
            lim_c[ch] <= {2'b00, 6'($random(seed))} + 8'h20;
            hyst <= {4'h0, 4'($random(seed))};
            v = 8'($random(seed));
         end
         of = ch & 1'($random(seed));
         step(ch, v, of);
         rdst(1'($random(seed)));
         setmask(1'b0);
      end
      report_and_stop();
   end
endmodule
